// [csift_pkg.sv]
/*
 * constants, register indices, field positions and state codes for the
 * can status, flag, acceptance filter and prescaler block.
 * assumes an 8-bit apb byte address (byte address = index * 4).
 */
package csift_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_CTRL  = 6'h20;
  localparam logic [5:0] IDX_CMD   = 6'h21;
  localparam logic [5:0] IDX_STAT  = 6'h22;
  localparam logic [5:0] IDX_FLAGS = 6'h23;
  localparam logic [5:0] IDX_ACODE = 6'h24;
  localparam logic [5:0] IDX_AMASK = 6'h25;
  localparam logic [5:0] IDX_BT0   = 6'h26;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_RR  = 0;
  localparam int CTRL_RIE = 1;
  localparam int CTRL_TIE = 2;
  localparam int CTRL_EIE = 3;
  localparam int CTRL_OIE = 4;
  localparam int CMD_TR    = 0;
  localparam int CMD_AT    = 1;
  localparam int CMD_RRB   = 2;
  localparam int CMD_COS   = 3;
  localparam int CMD_SLEEP = 4;
  localparam int FLG_RX   = 0;
  localparam int FLG_TX   = 1;
  localparam int FLG_ERR  = 2;
  localparam int FLG_OVR  = 3;
  localparam int FLG_WAKE = 4;
  localparam int BT0_SJW_LSB = 6;

  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [7:0] STAT_RESET   = 8'h0C;
  localparam logic [7:0] CMD_READ     = 8'hFF;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] FLAG_RR_KEEP = 8'h14;
  localparam logic [8:0] TEC_BUSOFF   = 9'h100;
  localparam logic [8:0] ERR_WARN     = 9'h060;
  localparam logic [6:0] RECOVER_LAST = 7'h7F;
  localparam logic [1:0] RXB_BOTH     = 2'h2;
  localparam logic [2:0] SJW_BASE     = 3'h1;

  // bus-off recovery state
  typedef enum logic [2:0] {
    BO_RUN     = 3'b001,
    BO_HOLD    = 3'b010,
    BO_RECOVER = 3'b100
  } csift_bo_t;

endpackage : csift_pkg

// [csift_cfg_if.sv]
/*
 * configuration and result signals between the block's top and its
 * acceptance filter and time quantum divider.
 * assumes all parties share pclk.
 */
`timescale 1ns/100ps
interface csift_cfg_if;
  logic [7:0] accept_code;
  logic [7:0] accept_mask;
  logic [7:0] rx_id;
  logic       id_valid;
  logic       id_accepted;
  logic [5:0] prescaler_field;
  logic       tq_tick;

  modport ctl  (output accept_code, accept_mask, rx_id, id_valid, prescaler_field,
                input  id_accepted, tq_tick);
  modport filt (input  accept_code, accept_mask, rx_id, id_valid,
                output id_accepted);
  modport div  (input  prescaler_field,
                output tq_tick);
endinterface : csift_cfg_if

// [csift_units.sv]
/*
 * acceptance filter and time quantum divider.
 * assumes pclk and presetn of the top; configuration is held stable by
 * software while the block runs.
 */
`timescale 1ns/100ps

// ******************************************************************
// acceptance filter
// ******************************************************************
module csift_accept
  import csift_pkg::*;
(
  // system
  input wire logic  pclk,
  input wire logic  presetn,
  // configuration and result
  csift_cfg_if.filt cfg
);
  // latch the verdict when the identifier top bits arrive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.id_accepted <= 1'b0;
    end else if (cfg.id_valid) begin
      cfg.id_accepted <= &(~(cfg.rx_id ^ cfg.accept_code) | cfg.accept_mask); // [R18]
    end
  end

  property p_accept;
    @(posedge pclk) disable iff (!presetn)
    cfg.id_valid |=> cfg.id_accepted ==
      &(~($past(cfg.rx_id) ^ $past(cfg.accept_code)) | $past(cfg.accept_mask));
  endproperty
  a_accept: assert property (p_accept) else $error("acceptance verdict wrong"); // [R18]
endmodule : csift_accept

// ******************************************************************
// time quantum divider
// ******************************************************************
module csift_tq_div
  import csift_pkg::*;
(
  // system
  input wire logic pclk,
  input wire logic presetn,
  // configuration and tick
  csift_cfg_if.div cfg
);
  logic [5:0] cnt;

  // one tick every prescaler_field+1 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt         <= 6'h00;
      cfg.tq_tick <= 1'b0;
    end else if (cnt >= cfg.prescaler_field) begin // [R22]
      cnt         <= 6'h00;
      cfg.tq_tick <= 1'b1;
    end else begin
      cnt         <= cnt + 6'h01;
      cfg.tq_tick <= 1'b0;
    end
  end

  property p_tq_gap;
    @(posedge pclk) disable iff (!presetn)
    cfg.tq_tick && cfg.prescaler_field != 6'h00 |=> !cfg.tq_tick;
  endproperty
  a_tq_gap: assert property (p_tq_gap) else $error("tick too soon"); // [R22]

  property p_tq_unit;
    @(posedge pclk) disable iff (!presetn)
    (cfg.prescaler_field == 6'h00) [*3] |-> cfg.tq_tick;
  endproperty
  a_tq_unit: assert property (p_tq_unit) else $error("prescale of one lost"); // [R22]
endmodule : csift_tq_div

// [csift_top.sv]
/*
 * status, interrupt flag, acceptance filter and prescaler control of a
 * can controller, reached over apb with 8-bit registers in low bits.
 * assumes the protocol engine drives the event pulses, counters and id
 * synchronous to pclk; flags are polled, no interrupt line.
 */
// Function
// R1: transmit error count 256 sets bus_off_flag and reset_request, stays off bus.
// R2: after reset_request cleared, 128 runs of 11 recessive end bus-off, clear counters.
// R3: error_warning_flag follows either error counter at or above 96.
// R4: transmitting_flag on send start; receiving_flag on reception or lost arbitration.
// R5: receiving_flag never sets while bus is stuck dominant.
// R6: tx_request clears tx_complete_flag; sets again on successful send.
// R7: abort before sending frees buffer and leaves tx_complete_flag clear.
// R8: tx_buffer_free low while pending or sending; locked writes are dropped.
// R9: both buffers full plus new message sets overrun; clear_overrun_cmd clears it.
// R10: outgoing frame takes a receive buffer and can cause overrun; here it never takes a buffer, only overruns when both are full.
// R11: rx_buffer_full on new message; release hands over second buffer at once.
// R12: flag bits read-only, cleared by reading the flag register.
// R13: bus activity while asleep clears sleep and sets wake_flag.
// R14: overrun_irq_flag on overrun if enabled; cleared by read or reset_request.
// R15: error_irq_flag on error or bus-off change if enabled; cleared by read.
// R16: tx_irq_flag at send end if buffer free and enabled.
// R17: rx_irq_flag with rx_buffer_full if enabled, never for own frame.
// R18: accept when unmasked code bits equal identifier top 8 bits.
// R19: accepted message stored into free buffer, else overrun.
// R20: code, mask and timing registers reachable only while reset_request set.
// R21: sync_jump_width plus one gives 1 to 4 quanta.
// R22: prescaler_field plus one divides clock, 1 to 64.
// R23: reset_request aborts transmission and reception, enters reset state.
`timescale 1ns/100ps
module csift_top
  import csift_pkg::*;
(
  // system
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // protocol engine events and counters
  input  wire logic [8:0]  tx_err_count,
  input  wire logic [8:0]  rx_err_count,
  input  wire logic        tx_started,
  input  wire logic        tx_done_ok,
  input  wire logic        tx_arb_lost,
  input  wire logic        rx_started,
  input  wire logic        rx_frame_done,
  input  wire logic [7:0]  rx_id,
  input  wire logic        rx_id_valid,
  input  wire logic        bus_stuck_dominant,
  input  wire logic        recessive11_seen,
  input  wire logic        bus_activity,
  // controls to the protocol engine
  output logic             reset_request,
  output logic             tx_go,
  output logic             err_counters_clear,
  output logic             sleep_active,
  output logic             rx_store,
  output logic      [2:0]  sync_jump_tq,
  output logic             tq_tick
);

  // ****************************************************************
  // state
  // ****************************************************************
  csift_bo_t  bo_state;
  logic [6:0] rec_cnt;
  logic       bus_off_flag, error_warning_flag, prev_bus_off, prev_warn;
  logic       transmitting_flag, receiving_flag, tx_complete_flag, tx_buffer_free;
  logic       tx_pending, data_overrun, rx_buffer_full;
  logic [1:0] rx_count;
  logic       rx_irq_enable, tx_irq_enable, error_irq_enable, overrun_irq_enable;
  logic [7:0] irq_flags, rd_snap, accept_code, accept_mask, bus_timing_zero;
  logic [7:0] next_flags, flag_set, rd_mux;
  logic [1:0] rx_eff;
  logic       overrun_evt, rx_new, wake_evt;

  csift_cfg_if cfg ();

  function automatic logic reg_hit(input logic [7:0] a, input logic [5:0] idx);
    return (a[7:2] == idx) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup   = psel && !penable;
  wire acc     = psel && penable && pready;
  wire wr_en   = acc && pwrite;
  wire rd_en   = acc && !pwrite;
  wire mapped  = (paddr[7:2] >= IDX_CTRL) && (paddr[7:2] <= IDX_BT0) && (paddr[1:0] == 2'b00);
  wire cmd_wr  = wr_en && reg_hit(paddr, IDX_CMD) && !reset_request;
  wire ctrl_wr = wr_en && reg_hit(paddr, IDX_CTRL);
  wire cfg_wr  = wr_en && reset_request; // [R20]
  wire tr_cmd  = cmd_wr && pwdata[CMD_TR];
  wire at_cmd  = cmd_wr && pwdata[CMD_AT];
  wire rrb_cmd = cmd_wr && pwdata[CMD_RRB];
  wire cos_cmd = cmd_wr && pwdata[CMD_COS];
  // engine count still shows bus-off level while its clear is in flight
  wire busoff_hit = (tx_err_count >= TEC_BUSOFF) && !err_counters_clear;

  // read data selection
  always_comb begin
    rd_mux = 8'h00;
    if (reg_hit(paddr, IDX_CTRL)) begin
      rd_mux = {3'h0, overrun_irq_enable, error_irq_enable, tx_irq_enable,
                rx_irq_enable, reset_request};
    end else if (reg_hit(paddr, IDX_CMD)) begin
      rd_mux = CMD_READ;
    end else if (reg_hit(paddr, IDX_STAT)) begin
      rd_mux = {bus_off_flag, error_warning_flag, transmitting_flag, receiving_flag,
                tx_complete_flag, tx_buffer_free, data_overrun, rx_buffer_full};
    end else if (reg_hit(paddr, IDX_FLAGS)) begin
      rd_mux = irq_flags;
    end else if (reset_request) begin // [R20]
      if (reg_hit(paddr, IDX_ACODE)) rd_mux = accept_code;
      else if (reg_hit(paddr, IDX_AMASK)) rd_mux = accept_mask;
      else if (reg_hit(paddr, IDX_BT0)) rd_mux = bus_timing_zero;
    end
  end

  // one wait-free access phase; data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      rd_snap <= 8'h00;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= {24'h00_0000, rd_mux};
      rd_snap <= (!pwrite && reg_hit(paddr, IDX_FLAGS)) ? irq_flags : 8'h00;
    end else if (acc) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // control register and configuration
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_request      <= 1'b1;
      rx_irq_enable      <= 1'b0;
      tx_irq_enable      <= 1'b0;
      error_irq_enable   <= 1'b0;
      overrun_irq_enable <= 1'b0;
    end else begin
      if (ctrl_wr && !reset_request) begin
        rx_irq_enable      <= pwdata[CTRL_RIE];
        tx_irq_enable      <= pwdata[CTRL_TIE];
        error_irq_enable   <= pwdata[CTRL_EIE];
        overrun_irq_enable <= pwdata[CTRL_OIE];
      end
      if (bo_state == BO_RUN && busoff_hit) reset_request <= 1'b1; // [R1]
      else if (ctrl_wr) reset_request <= pwdata[CTRL_RR];
    end
  end

  // filter and timing configuration, writable only in reset state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_code     <= CFG_RESET;
      accept_mask     <= CFG_RESET;
      bus_timing_zero <= CFG_RESET;
      sync_jump_tq    <= SJW_BASE;
    end else begin
      if (cfg_wr && reg_hit(paddr, IDX_ACODE)) accept_code <= pwdata[7:0]; // [R20]
      if (cfg_wr && reg_hit(paddr, IDX_AMASK)) accept_mask <= pwdata[7:0]; // [R20]
      if (cfg_wr && reg_hit(paddr, IDX_BT0)) bus_timing_zero <= pwdata[7:0]; // [R20]
      sync_jump_tq <= {1'b0, bus_timing_zero[BT0_SJW_LSB +: 2]} + SJW_BASE; // [R21]
    end
  end

  assign cfg.accept_code     = accept_code;
  assign cfg.accept_mask     = accept_mask;
  assign cfg.rx_id           = rx_id;
  assign cfg.id_valid        = rx_id_valid;
  assign cfg.prescaler_field = bus_timing_zero[5:0]; // [R22]
  assign tq_tick             = cfg.tq_tick;

  csift_accept u_accept (.pclk(pclk), .presetn(presetn), .cfg(cfg.filt));
  csift_tq_div u_tq_div (.pclk(pclk), .presetn(presetn), .cfg(cfg.div));

  // ****************************************************************
  // bus-off and error warning
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_state           <= BO_RUN;
      bus_off_flag       <= 1'b0;
      rec_cnt            <= 7'h00;
      err_counters_clear <= 1'b0;
    end else begin
      err_counters_clear <= 1'b0;
      case (bo_state)
        BO_RUN: begin
          if (busoff_hit) begin
            bo_state     <= BO_HOLD;
            bus_off_flag <= 1'b1; // [R1]
          end
        end
        BO_HOLD: begin
          rec_cnt <= 7'h00;
          if (!reset_request) bo_state <= BO_RECOVER;
        end
        BO_RECOVER: begin
          if (reset_request) begin
            bo_state <= BO_HOLD;
          end else if (recessive11_seen) begin
            rec_cnt <= rec_cnt + 7'h01;
            if (rec_cnt == RECOVER_LAST) begin // [R2]
              bo_state           <= BO_RUN;
              bus_off_flag       <= 1'b0;
              err_counters_clear <= 1'b1;
            end
          end
        end
        default: bo_state <= BO_RUN;
      endcase
    end
  end

  // warning level and change tracking for the error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_warning_flag <= 1'b0;
      prev_bus_off       <= 1'b0;
      prev_warn          <= 1'b0;
    end else begin
      error_warning_flag <= (tx_err_count >= ERR_WARN) || (rx_err_count >= ERR_WARN); // [R3]
      prev_bus_off       <= bus_off_flag;
      prev_warn          <= error_warning_flag;
    end
  end

  // ****************************************************************
  // transmit path
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pending        <= 1'b0;
      transmitting_flag <= 1'b0;
      tx_complete_flag  <= 1'b1;
      tx_buffer_free    <= 1'b1;
      tx_go             <= 1'b0;
    end else if (reset_request) begin // [R23]
      tx_pending        <= 1'b0;
      transmitting_flag <= 1'b0;
      tx_complete_flag  <= 1'b1;
      tx_buffer_free    <= 1'b1;
      tx_go             <= 1'b0;
    end else begin
      if (tx_started && tx_pending) transmitting_flag <= 1'b1; // [R4]
      if (tx_done_ok) begin
        transmitting_flag <= 1'b0;
        tx_pending        <= 1'b0;
        tx_buffer_free    <= 1'b1;
        tx_complete_flag  <= 1'b1; // [R6]
      end else if (tx_arb_lost) begin
        transmitting_flag <= 1'b0;
      end
      if (at_cmd && tx_pending && !transmitting_flag && !tx_started) begin
        tx_pending     <= 1'b0; // [R7]
        tx_buffer_free <= 1'b1;
      end
      if (tr_cmd) begin
        tx_pending       <= 1'b1;
        tx_buffer_free   <= 1'b0; // [R8]
        tx_complete_flag <= 1'b0; // [R6]
      end
      tx_go <= tx_pending && !transmitting_flag && !bus_off_flag;
    end
  end

  // ****************************************************************
  // receive path and double buffer
  // ****************************************************************
  wire rx_keep  = rx_frame_done && receiving_flag && cfg.id_accepted; // [R18]
  wire own_copy = tx_started && tx_pending; // [R10]

  always_comb begin
    rx_eff      = (rrb_cmd && rx_count != 2'h0) ? rx_count - 2'h1 : rx_count; // [R11]
    overrun_evt = (rx_keep || own_copy) && (rx_eff == RXB_BOTH); // [R9] [R19]
    rx_new      = rx_keep && (rx_eff != RXB_BOTH); // [R19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_count       <= 2'h0;
      rx_buffer_full <= 1'b0;
      data_overrun   <= 1'b0;
      rx_store       <= 1'b0;
      receiving_flag <= 1'b0;
    end else if (reset_request) begin // [R23]
      rx_count       <= 2'h0;
      rx_buffer_full <= 1'b0;
      data_overrun   <= 1'b0;
      rx_store       <= 1'b0;
      receiving_flag <= 1'b0;
    end else begin
      rx_count       <= rx_eff + {1'b0, rx_new};
      rx_buffer_full <= (rx_eff != 2'h0) || rx_new; // [R11]
      rx_store       <= rx_new;
      if (overrun_evt) data_overrun <= 1'b1; // [R9]
      else if (cos_cmd) data_overrun <= 1'b0;
      if ((rx_started || tx_arb_lost) && !bus_stuck_dominant) begin
        receiving_flag <= 1'b1; // [R4] [R5]
      end else if (rx_frame_done) begin
        receiving_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // sleep and wake-up
  // ****************************************************************
  assign wake_evt = sleep_active && (bus_activity || receiving_flag || transmitting_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_active <= 1'b0;
    end else if (wake_evt) begin
      sleep_active <= 1'b0; // [R13]
    end else if (cmd_wr) begin
      sleep_active <= pwdata[CMD_SLEEP];
    end
  end

  // ****************************************************************
  // flag register: sets win over read clear
  // ****************************************************************
  always_comb begin
    flag_set           = 8'h00;
    flag_set[FLG_RX]   = rx_new && rx_irq_enable; // [R17]
    flag_set[FLG_TX]   = tx_done_ok && !tr_cmd && tx_irq_enable && !reset_request; // [R16]
    flag_set[FLG_ERR]  = error_irq_enable &&
                         ((bus_off_flag != prev_bus_off) || (error_warning_flag != prev_warn)); // [R15]
    flag_set[FLG_OVR]  = overrun_evt && overrun_irq_enable && !reset_request; // [R14]
    flag_set[FLG_WAKE] = wake_evt; // [R13]
    next_flags = (irq_flags & ~(rd_en ? rd_snap : 8'h00)) | flag_set; // [R12]
    if (reset_request) next_flags = next_flags & FLAG_RR_KEEP; // [R14] [R16] [R17]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags <= 8'h00;
    end else begin
      irq_flags <= next_flags;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_bus_off_entry;
    bo_state == BO_RUN && busoff_hit |=> bus_off_flag && reset_request;
  endproperty
  a_bus_off_entry: assert property (p_bus_off_entry) else $error("bus-off entry missed"); // [R1]

  property p_recover;
    $fell(bus_off_flag) |-> err_counters_clear && $past(rec_cnt) == RECOVER_LAST;
  endproperty
  a_recover: assert property (p_recover) else $error("early bus-off exit"); // [R2]

  property p_warn;
    1'b1 |=> error_warning_flag ==
      ($past(tx_err_count) >= ERR_WARN || $past(rx_err_count) >= ERR_WARN);
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag wrong"); // [R3]

  property p_stuck;
    $rose(receiving_flag) |-> !$past(bus_stuck_dominant);
  endproperty
  a_stuck: assert property (p_stuck) else $error("receive set while stuck"); // [R5]

  sequence s_tx_req;
    tr_cmd;
  endsequence
  sequence s_locked;
    !tx_complete_flag && !tx_buffer_free;
  endsequence
  property p_tx_req;
    s_tx_req |=> s_locked;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("request did not lock"); // [R6] [R8]

  property p_abort;
    at_cmd && tx_pending && !transmitting_flag && !tx_started && !tr_cmd
      |=> tx_buffer_free && !tx_complete_flag ##1 !tx_complete_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("abort handling wrong"); // [R7]

  property p_overrun;
    overrun_evt |=> data_overrun && rx_buffer_full;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // [R9] [R10]

  property p_rd_clear;
    rd_en && reg_hit(paddr, IDX_FLAGS) && flag_set == 8'h00 |=> (irq_flags & $past(rd_snap)) == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read"); // [R12]

  property p_wake;
    wake_evt |=> irq_flags[FLG_WAKE] && !sleep_active;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up lost"); // [R13]

  property p_sjw;
    1'b1 |=> sync_jump_tq == {1'b0, $past(bus_timing_zero[7:6])} + SJW_BASE;
  endproperty
  a_sjw: assert property (p_sjw) else $error("jump width coding wrong"); // [R21]

endmodule : csift_top

// [csift_engine_model.sv]
/* csift engine model: protocol engine and bus side of the block.
   assumes the bench's pclk; every event is a one-cycle pulse. */
`timescale 1ns/100ps
module csift_engine_model (
  // system
  input  wire logic       pclk,
  // controls from block
  input  wire logic       tx_go,
  input  wire logic       err_counters_clear,
  // events to block
  output logic      [8:0] tx_err_count,
  output logic            tx_started,
  output logic            tx_done_ok,
  output logic            rx_started,
  output logic            rx_frame_done,
  output logic      [7:0] rx_id,
  output logic            rx_id_valid,
  output logic            recessive11_seen
);
  // idle levels
  initial {tx_err_count, tx_started, tx_done_ok, rx_started, rx_frame_done} = '0;
  initial {rx_id, rx_id_valid, recessive11_seen} = '0;
  // transmit error count restarts when recovery ends
  always @(posedge pclk) if (err_counters_clear) tx_err_count <= 9'h000;
  // send a pending frame some cycles after go
  initial forever begin
    @(posedge pclk);
    if (tx_go === 1'b1) begin
      repeat (3) @(posedge pclk);
      if (tx_go !== 1'b1) continue;
      tx_started <= 1'b1;
      @(posedge pclk) tx_started <= 1'b0;
      repeat (5) @(posedge pclk);
      tx_done_ok <= 1'b1;
      @(posedge pclk) tx_done_ok <= 1'b0;
    end
  end
  // one received frame, id valid before frame end
  task rx_frame(input logic [7:0] id);
    @(posedge pclk) rx_started <= 1'b1;
    @(posedge pclk) rx_started <= 1'b0;
    rx_id <= id;
    rx_id_valid <= 1'b1;
    @(posedge pclk) rx_id_valid <= 1'b0;
    rx_id <= ~id; // id no longer held
    @(posedge pclk) rx_frame_done <= 1'b1;
    @(posedge pclk) rx_frame_done <= 1'b0;
  endtask : rx_frame
  // n runs of eleven recessive bits
  task recess(input int n);
    repeat (n) begin
      @(posedge pclk) recessive11_seen <= 1'b1;
      @(posedge pclk) recessive11_seen <= 1'b0;
    end
  endtask : recess
endmodule : csift_engine_model

// [csift_top_test.sv]
/* csift_top_test: apb register tests of the status and flag block.
   assumes csift_pkg and the engine model; no random stimulus. */
`timescale 1ns/100ps
module csift_top_test;
  import csift_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [7:0] paddr = 0, r;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, rr, tx_go, ecc, tx_st, tx_ok, rx_st, rx_done, idv, r11;
  logic [8:0] tec, rec = 0;
  logic stk = 0, act = 0, slp, tq;
  logic [7:0] rid;
  logic [2:0] sjw;
  int err_count = 0, checks_done = 0, n;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  csift_engine_model eng (.pclk(pclk), .tx_go(tx_go), .err_counters_clear(ecc),
    .tx_err_count(tec), .tx_started(tx_st), .tx_done_ok(tx_ok), .rx_started(rx_st),
    .rx_frame_done(rx_done), .rx_id(rid), .rx_id_valid(idv), .recessive11_seen(r11));
  csift_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_err_count(tec), .rx_err_count(rec), .tx_started(tx_st),
    .tx_done_ok(tx_ok), .tx_arb_lost(1'b0), .rx_started(rx_st), .rx_frame_done(rx_done),
    .rx_id(rid), .rx_id_valid(idv), .bus_stuck_dominant(stk), .recessive11_seen(r11),
    .bus_activity(act), .reset_request(rr), .tx_go(tx_go), .err_counters_clear(ecc),
    .sleep_active(slp), .rx_store(), .sync_jump_tq(sjw), .tq_tick(tq));
  // compare and count
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task rd(input logic [5:0] i, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk("register", r & m, e);
  endtask : rd
  task finish_test;
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_STAT, 8'hFF, 8'h0C);
    rd(IDX_FLAGS, 8'hFF, 8'h00);
    rd(IDX_CTRL, 8'hFF, 8'h01);
    rd(IDX_CMD, 8'hFF, 8'hFF);
    apb(1'b0, 6'h3F, 8'h00);
    chk("pslverr", {7'h00, slv}, 8'h01);
    wr(IDX_ACODE, 8'hA5);
    wr(IDX_AMASK, 8'h0F);
    wr(IDX_BT0, 8'hC1);
    rd(IDX_ACODE, 8'hFF, 8'hA5);
    rd(IDX_BT0, 8'hFF, 8'hC1);
    chk("sjw", {5'h00, sjw}, 8'h04);
    n = 0;
    repeat (4) @(posedge pclk) n += tq;
    chk("ticks", n[7:0], 8'h02);
    wr(IDX_CTRL, 8'h06);
    wr(IDX_CTRL, 8'h06);
    rd(IDX_AMASK, 8'hFF, 8'h00);
    wr(IDX_CMD, 8'h01);
    rd(IDX_STAT, 8'h0C, 8'h00);
    @(posedge tx_ok);
    @(posedge pclk);
    rd(IDX_STAT, 8'h3C, 8'h0C);
    rd(IDX_FLAGS, 8'h03, 8'h02);
    rd(IDX_FLAGS, 8'h02, 8'h00);
    wr(IDX_CMD, 8'h01);
    wr(IDX_CMD, 8'h02);
    repeat (12) @(posedge pclk);
    rd(IDX_STAT, 8'h0C, 8'h04);
    rd(IDX_FLAGS, 8'h02, 8'h00);
    eng.rx_frame(8'h53);
    rd(IDX_FLAGS, 8'h01, 8'h00);
    eng.rx_frame(8'hA3);
    rd(IDX_FLAGS, 8'h01, 8'h01);
    rd(IDX_STAT, 8'h01, 8'h01);
    stk <= 1'b1;
    eng.rx_frame(8'hA3);
    stk <= 1'b0;
    rd(IDX_FLAGS, 8'h01, 8'h00);
    eng.rx_frame(8'hA3);
    eng.rx_frame(8'hA3);
    rd(IDX_STAT, 8'h03, 8'h03);
    wr(IDX_CMD, 8'h08);
    rd(IDX_STAT, 8'h03, 8'h01);
    wr(IDX_CMD, 8'h10);
    @(posedge pclk) chk("sleep", {7'h00, slp}, 8'h01);
    act <= 1'b1;
    rd(IDX_FLAGS, 8'h10, 8'h10);
    act <= 1'b0;
    chk("sleep", {7'h00, slp}, 8'h00);
    rec <= 9'h060;
    rd(IDX_STAT, 8'hC0, 8'h40);
    rec <= 9'h000;
    eng.tx_err_count <= 9'h100;
    rd(IDX_STAT, 8'hC0, 8'hC0);
    rd(IDX_CTRL, 8'h01, 8'h01);
    wr(IDX_CTRL, 8'h00);
    eng.recess(127);
    rd(IDX_STAT, 8'h80, 8'h80);
    eng.recess(1);
    repeat (2) @(posedge pclk);
    rd(IDX_STAT, 8'hC0, 8'h00);
    finish_test;
  end
endmodule : csift_top_test
